//--- verilog/sdvc_defines.svh
// Constants for the synthesiser divider and oscillator calibration register bank.
`ifndef SDVC_DEFINES_SVH
`define SDVC_DEFINES_SVH

`define SDVC_ADDR_W         10
`define SDVC_IDX_LSB        2
`define SDVC_IDX_MSB        9

// Register indices; the byte address is four times the index.
`define SDVC_IDX_DIV_MODE   8'h30
`define SDVC_IDX_GEN_CTRL   8'h31
`define SDVC_IDX_RF_RDIV    8'h38
`define SDVC_IDX_RF_IDIV    8'h39
`define SDVC_IDX_FRAC_LO    8'h3A
`define SDVC_IDX_FRAC_HI    8'h3B
`define SDVC_IDX_IF_NDIV    8'h3C
`define SDVC_IDX_IF_RDIV    8'h3D
`define SDVC_IDX_IF_CUR     8'h3E
`define SDVC_IDX_CAL_CTRL   8'h50
`define SDVC_IDX_BIAS_CODE  8'h51
`define SDVC_IDX_BIAS_TIME  8'h52
`define SDVC_IDX_HF_CODE    8'h53
`define SDVC_IDX_HF_COUNT   8'h54
`define SDVC_IDX_HF_TIMES   8'h55
`define SDVC_IDX_HF_START   8'h56
`define SDVC_IDX_LF_CODE    8'h57
`define SDVC_IDX_CAL_STAT   8'h5E
`define SDVC_IDX_RB_RDIV    8'hC8
`define SDVC_IDX_RB_IDIV    8'hC9
`define SDVC_IDX_RB_FLO     8'hCA
`define SDVC_IDX_RB_FHI     8'hCB
`define SDVC_IDX_RB_NDIV    8'hCC
`define SDVC_IDX_RB_RDIVIF  8'hCD
`define SDVC_IDX_RB_CUR     8'hCE

// Reset values.
`define SDVC_RST_RF_IDIV    16'h0080
`define SDVC_RST_IF_NDIV    16'h0080
`define SDVC_RST_IF_RDIV    16'h0002
`define SDVC_RST_MCLK_MHZ   8'h14
`define SDVC_RST_BIAS_TIME  8'h06
`define SDVC_RST_HF_COUNT   16'h015E
`define SDVC_RST_HF_TIMES   16'h0D06
`define SDVC_RST_HF_START   16'h012C

// Field positions.
`define SDVC_MODE_INT_BIT   0
`define SDVC_MODE_R24_BIT   1
`define SDVC_GEN_IFRUN_BIT  5
`define SDVC_CUR_BIAS_BIT   7
`define SDVC_START_LF_BIT   2
`define SDVC_START_HF_BIT   1
`define SDVC_START_BIAS_BIT 0
`define SDVC_MCLK_LSB       8

// Timing and scaling.
`define SDVC_SETTLE_UNIT_US 16'h0008
`define SDVC_PUMP_STEP_UA   9'h019
`define SDVC_RESP_OKAY      2'b00
`define SDVC_RESP_SLVERR    2'b10

`endif

//--- verilog/sdvc_pkg.sv
// Types shared by the synthesiser register bank.
`default_nettype none
package sdvc_pkg;
	// Phases of the high-frequency oscillator calibration sequence.
	typedef enum logic [1:0] {
		HF_IDLE,
		HF_STARTUP,
		HF_LOOP_SETTLE,
		HF_CLOSED_SETTLE
	} sdvc_hf_phase_t;
endpackage
`default_nettype wire

//--- verilog/sdvc_regs.sv
// Divider and oscillator calibration register bank with an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sdvc_defines.svh"
module sdvc_regs #(
	parameter int LF_CAL_US = 325
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ifPdClk,
	output logic [35:0]      rfDivRatio,
	output logic [6:0]       rfRefDivider,
	output logic [13:0]      ifFeedbackDivider,
	output logic [8:0]       ifRefDividerApplied,
	output logic             ifPllRun,
	output logic             ifBiasHigh,
	output logic [8:0]       ifPumpCurrentUa,
	output logic [4:0]       biasCalCode,
	output logic [8:0]       hfOscCalCode,
	output logic [9:0]       hfOscCalCycles,
	output logic [8:0]       lfOscCalCode,
	output logic [2:0]       calProgress,
	output logic             usTick
);
	// Stored register contents.
	logic [7:0]  divMode_r;
	logic [7:0]  genCtrl_r;
	logic [7:0]  rfRdiv_r;
	logic [15:0] rfIdiv_r;
	logic [15:0] fracLo_r;
	logic [7:0]  fracHi_r;
	logic [15:0] ifNdiv_r;
	logic [15:0] ifRdiv_r;
	logic [7:0]  ifCur_r;
	logic [7:0]  mclkMhz_r;
	logic [7:0]  biasCode_r;
	logic [7:0]  biasTime_r;
	logic [15:0] hfCode_r;
	logic [15:0] hfCount_r;
	logic [15:0] hfTimes_r;
	logic [15:0] hfStart_r;
	logic [15:0] lfCode_r;

	// Bus channel state.
	logic        awHeld_r;
	logic [9:0]  awAddr_r;
	logic        wHeld_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;

	// Merge a strobed write into an old word, lane by lane.
	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Writable register indices; anything else answers with an error.
	function automatic logic isWritable(input logic [7:0] idx);
		return (idx == `SDVC_IDX_DIV_MODE) || (idx == `SDVC_IDX_GEN_CTRL) ||
			((idx >= `SDVC_IDX_RF_RDIV) && (idx <= `SDVC_IDX_IF_CUR)) ||
			((idx >= `SDVC_IDX_CAL_CTRL) && (idx <= `SDVC_IDX_LF_CODE));
	endfunction

	// Channel handshakes; a write answer must be taken before the next write request.
	wire logic [7:0]  wrIdx   = awAddr_r[`SDVC_IDX_MSB:`SDVC_IDX_LSB];
	wire logic [7:0]  rdIdx   = s_axi_araddr[`SDVC_IDX_MSB:`SDVC_IDX_LSB];
	wire logic        doWrite = ce && awHeld_r && wHeld_r && !bvalid_r;
	wire logic        wrOk    = isWritable(wrIdx);
	wire logic        doRead  = s_axi_arvalid && s_axi_arready;
	assign s_axi_awready = ce && !awHeld_r && !bvalid_r;
	assign s_axi_wready  = ce && !wHeld_r && !bvalid_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	// Write data after byte strobes over a zero word; no register uses it, each merges into its own old value.
	wire logic [31:0] wMerged16 = mergeLanes({16'h0000, 16'h0000}, wData_r, wStrb_r);
	wire logic        wrSel     = doWrite && wrOk;

	// Address and data are captured independently, in either order.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_r <= 1'b0;
			awAddr_r <= 10'h000;
			wHeld_r  <= 1'b0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
		end
	end

	// The write answer follows once both halves are in.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `SDVC_RESP_OKAY;
		end else if (ce) begin
			if (doWrite) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wrOk ? `SDVC_RESP_OKAY : `SDVC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Register storage; new fraction words land at once even with the loop running.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			divMode_r  <= 8'h00;
			genCtrl_r  <= 8'h00;
			rfRdiv_r   <= 8'h00;
			rfIdiv_r   <= `SDVC_RST_RF_IDIV;
			fracLo_r   <= 16'h0000;
			fracHi_r   <= 8'h00;
			ifNdiv_r   <= `SDVC_RST_IF_NDIV;
			ifRdiv_r   <= `SDVC_RST_IF_RDIV;
			ifCur_r    <= 8'h00;
			mclkMhz_r  <= `SDVC_RST_MCLK_MHZ;
			biasCode_r <= 8'h00;
			biasTime_r <= `SDVC_RST_BIAS_TIME;
			hfCode_r   <= 16'h0000;
			hfCount_r  <= `SDVC_RST_HF_COUNT;
			hfTimes_r  <= `SDVC_RST_HF_TIMES;
			hfStart_r  <= `SDVC_RST_HF_START;
			lfCode_r   <= 16'h0000;
		end else if (ce && wrSel) begin
			unique case (wrIdx)
				`SDVC_IDX_DIV_MODE:  divMode_r  <= 8'(mergeLanes({24'h00_0000, divMode_r}, wData_r, wStrb_r));
				`SDVC_IDX_GEN_CTRL:  genCtrl_r  <= 8'(mergeLanes({24'h00_0000, genCtrl_r}, wData_r, wStrb_r));
				`SDVC_IDX_RF_RDIV:   rfRdiv_r   <= 8'(mergeLanes({24'h00_0000, rfRdiv_r}, wData_r, wStrb_r));
				`SDVC_IDX_RF_IDIV:   rfIdiv_r   <= 16'(mergeLanes({16'h0000, rfIdiv_r}, wData_r, wStrb_r));
				`SDVC_IDX_FRAC_LO:   fracLo_r   <= 16'(mergeLanes({16'h0000, fracLo_r}, wData_r, wStrb_r));
				`SDVC_IDX_FRAC_HI:   fracHi_r   <= 8'(mergeLanes({24'h00_0000, fracHi_r}, wData_r, wStrb_r));
				`SDVC_IDX_IF_NDIV:   ifNdiv_r   <= 16'(mergeLanes({16'h0000, ifNdiv_r}, wData_r, wStrb_r));
				`SDVC_IDX_IF_RDIV:   ifRdiv_r   <= 16'(mergeLanes({16'h0000, ifRdiv_r}, wData_r, wStrb_r));
				`SDVC_IDX_IF_CUR:    ifCur_r    <= 8'(mergeLanes({24'h00_0000, ifCur_r}, wData_r, wStrb_r));
				`SDVC_IDX_CAL_CTRL:  mclkMhz_r  <= 8'(mergeLanes({16'h0000, mclkMhz_r, 8'h00}, wData_r, wStrb_r)
					>> `SDVC_MCLK_LSB);
				`SDVC_IDX_BIAS_CODE: biasCode_r <= 8'(mergeLanes({24'h00_0000, biasCode_r}, wData_r, wStrb_r));
				`SDVC_IDX_BIAS_TIME: biasTime_r <= 8'(mergeLanes({24'h00_0000, biasTime_r}, wData_r, wStrb_r));
				`SDVC_IDX_HF_CODE:   hfCode_r   <= 16'(mergeLanes({16'h0000, hfCode_r}, wData_r, wStrb_r));
				`SDVC_IDX_HF_COUNT:  hfCount_r  <= 16'(mergeLanes({16'h0000, hfCount_r}, wData_r, wStrb_r));
				`SDVC_IDX_HF_TIMES:  hfTimes_r  <= 16'(mergeLanes({16'h0000, hfTimes_r}, wData_r, wStrb_r));
				`SDVC_IDX_HF_START:  hfStart_r  <= 16'(mergeLanes({16'h0000, hfStart_r}, wData_r, wStrb_r));
				`SDVC_IDX_LF_CODE:   lfCode_r   <= 16'(mergeLanes({16'h0000, lfCode_r}, wData_r, wStrb_r));
				default: ;
			endcase
		end
	end

	// Start bits are decoded from the write itself and never stored.
	wire logic ctrlWr     = wrSel && (wrIdx == `SDVC_IDX_CAL_CTRL) && wStrb_r[0];
	wire logic startBias  = ctrlWr && wData_r[`SDVC_START_BIAS_BIT];
	wire logic startHf    = ctrlWr && wData_r[`SDVC_START_HF_BIT];
	wire logic startLf    = ctrlWr && wData_r[`SDVC_START_LF_BIT];

	// Microsecond timebase; a zero setting is taken as one so the tick never stops.
	logic [7:0] tbCnt_r;
	wire logic [7:0] tbDiv  = (mclkMhz_r == 8'h00) ? 8'h01 : mclkMhz_r;
	wire logic       tbWrap = (tbCnt_r >= tbDiv - 8'h01);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tbCnt_r <= 8'h00;
		end else if (ce) begin
			tbCnt_r <= tbWrap ? 8'h00 : tbCnt_r + 8'h01;
		end
	end
	assign usTick = ce && tbWrap;

	// Bias calibration runs for the programmed settle period in microseconds.
	logic       biasBusy_r;
	logic [5:0] biasCnt_r;
	wire logic  biasDone = biasBusy_r && usTick && (biasCnt_r <= 6'h01);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			biasBusy_r <= 1'b0;
			biasCnt_r  <= 6'h00;
		end else if (ce) begin
			if (startBias) begin
				biasBusy_r <= 1'b1;
				biasCnt_r  <= biasTime_r[5:0];
			end else if (biasDone) begin
				biasBusy_r <= 1'b0;
			end else if (biasBusy_r && usTick) begin
				biasCnt_r <= biasCnt_r - 6'h01;
			end
		end
	end

	// High-frequency calibration: start-up wait, loop settle, then closed-loop settle.
	sdvc_pkg::sdvc_hf_phase_t hfPhase_r;
	logic [15:0] hfCnt_r;
	wire logic   hfStep     = usTick && (hfCnt_r <= 16'h0001);
	wire logic [15:0] loopUs   = 16'(hfTimes_r[15:8]) * `SDVC_SETTLE_UNIT_US;
	wire logic [15:0] closedUs = 16'(hfTimes_r[7:0]) * `SDVC_SETTLE_UNIT_US;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hfPhase_r <= sdvc_pkg::HF_IDLE;
			hfCnt_r   <= 16'h0000;
		end else if (ce) begin
			if (startHf) begin
				hfPhase_r <= sdvc_pkg::HF_STARTUP;
				hfCnt_r   <= hfStart_r;
			end else if (usTick) begin
				hfCnt_r <= hfCnt_r - 16'h0001;
				unique case (hfPhase_r)
					sdvc_pkg::HF_IDLE: hfCnt_r <= 16'h0000;
					sdvc_pkg::HF_STARTUP: if (hfStep) begin
						hfPhase_r <= sdvc_pkg::HF_LOOP_SETTLE;
						hfCnt_r   <= loopUs;
					end
					sdvc_pkg::HF_LOOP_SETTLE: if (hfStep) begin
						hfPhase_r <= sdvc_pkg::HF_CLOSED_SETTLE;
						hfCnt_r   <= closedUs;
					end
					sdvc_pkg::HF_CLOSED_SETTLE: if (hfStep) begin
						hfPhase_r <= sdvc_pkg::HF_IDLE;
					end
				endcase
			end
		end
	end

	// Low-frequency calibration holds busy for a fixed microsecond span.
	logic        lfBusy_r;
	logic [15:0] lfCnt_r;
	wire logic   lfDone = lfBusy_r && usTick && (lfCnt_r <= 16'h0001);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lfBusy_r <= 1'b0;
			lfCnt_r  <= 16'h0000;
		end else if (ce) begin
			if (startLf) begin
				lfBusy_r <= 1'b1;
				lfCnt_r  <= 16'(LF_CAL_US);
			end else if (lfDone) begin
				lfBusy_r <= 1'b0;
			end else if (lfBusy_r && usTick) begin
				lfCnt_r <= lfCnt_r - 16'h0001;
			end
		end
	end
	assign calProgress = {lfBusy_r, hfPhase_r != sdvc_pkg::HF_IDLE, biasBusy_r};

	// The phase detector clock arrives from another domain and is synchronised first.
	logic pdSync1_r;
	logic pdSync2_r;
	logic pdSync3_r;
	logic [8:0] ifRdivApplied_r;
	wire logic pdEdge = pdSync2_r && !pdSync3_r;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pdSync1_r       <= 1'b0;
			pdSync2_r       <= 1'b0;
			pdSync3_r       <= 1'b0;
			ifRdivApplied_r <= 9'(`SDVC_RST_IF_RDIV);
		end else if (ce) begin
			pdSync1_r <= ifPdClk;
			pdSync2_r <= pdSync1_r;
			pdSync3_r <= pdSync2_r;
			// Swapping only on a detector edge keeps a divider change from cutting a cycle short.
			if (pdEdge) begin
				ifRdivApplied_r <= ifRdiv_r[8:0];
			end
		end
	end
	assign ifRefDividerApplied = ifRdivApplied_r;

	// Fraction decode in units of 2^-24, then added to the integer divider.
	wire logic        fracInt  = divMode_r[`SDVC_MODE_INT_BIT];
	wire logic        frac24   = divMode_r[`SDVC_MODE_R24_BIT];
	wire logic [23:0] frac24W  = {fracHi_r, fracLo_r};
	wire logic [23:0] frac16W  = {fracLo_r, 8'h00};
	wire logic [23:0] fracSel  = fracInt ? 24'h00_0000 : (frac24 ? frac24W : frac16W);
	assign rfDivRatio = {14'h0000, rfIdiv_r[10:0], 11'h000} * 36'h0_0000_2000
		+ {{12{fracSel[23]}}, fracSel};

	// Settings presented to the analog loops.
	assign rfRefDivider      = rfRdiv_r[6:0];
	assign ifFeedbackDivider = ifNdiv_r[13:0];
	assign ifPllRun          = genCtrl_r[`SDVC_GEN_IFRUN_BIT];
	assign ifBiasHigh        = ifCur_r[`SDVC_CUR_BIAS_BIT];
	assign ifPumpCurrentUa   = `SDVC_PUMP_STEP_UA * {5'h00, ifCur_r[3:0]} + `SDVC_PUMP_STEP_UA;
	assign biasCalCode       = biasCode_r[4:0];
	assign hfOscCalCode      = hfCode_r[8:0];
	assign hfOscCalCycles    = hfCount_r[9:0];
	assign lfOscCalCode      = lfCode_r[8:0];

	// Read selection: readbacks mirror the stored write registers.
	function automatic logic [32:0] readMux(input logic [7:0] idx);
		unique case (idx)
			`SDVC_IDX_RB_RDIV:   return {1'b1, 24'h00_0000, rfRdiv_r};
			`SDVC_IDX_RB_IDIV:   return {1'b1, 16'h0000, rfIdiv_r};
			`SDVC_IDX_RB_FLO:    return {1'b1, 16'h0000, fracLo_r};
			`SDVC_IDX_RB_FHI:    return {1'b1, 24'h00_0000, fracHi_r};
			`SDVC_IDX_RB_NDIV:   return {1'b1, 16'h0000, ifNdiv_r};
			`SDVC_IDX_RB_RDIVIF: return {1'b1, 16'h0000, ifRdiv_r};
			`SDVC_IDX_RB_CUR:    return {1'b1, 24'h00_0000, ifCur_r};
			`SDVC_IDX_CAL_STAT:  return {1'b1, 29'h0000_0000, calProgress};
			default:             return 33'h0_0000_0000;
		endcase
	endfunction
	// A process, not a net: the mux reads registers that are not among its arguments.
	logic [32:0] rdSel;
	always_comb rdSel = readMux(rdIdx);

	// Read answer one edge after the address is taken, held until rready.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `SDVC_RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else if (ce) begin
			if (doRead) begin
				rvalid_r <= 1'b1;
				rresp_r  <= rdSel[32] ? `SDVC_RESP_OKAY : `SDVC_RESP_SLVERR;
				rdata_r  <= rdSel[31:0];
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	wire logic unusedBits = ^{wMerged16, biasTime_r[7:6], ifNdiv_r[15:14], ifRdiv_r[15:9]};
endmodule
`default_nettype wire

//--- tb/sdvc_host_model.sv
// Host processor model: an AXI4-Lite master that programs the register bank.
`timescale 1ns/100ps
`default_nettype none
module sdvc_host_model (
	input  wire logic        mclk,
	output logic [9:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [9:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// The bus is idle at time zero, so nothing is offered before the first call.
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 24'h00_0000;
		s_axi_wdata = 32'h0000_0000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	end

	// One transfer; each channel is held until its own handshake, so ok stays low only on a hang.
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r, output logic ok);
		ok = 1'b0;
		q = 32'h0000_0000;
		r = 2'b11;
		@(posedge mclk);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= 4'hF;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		for (int n = 0; n < 400; n++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (wr ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready)) begin
				r = wr ? s_axi_bresp : s_axi_rresp;
				q = s_axi_rdata;
				ok = 1'b1;
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				return;
			end
		end
	endtask
endmodule
`default_nettype wire

//--- tb/sdvc_regs_monitor.sv
// Port checker for the divider and calibration register bank.
`timescale 1ns/100ps
`default_nettype none
module sdvc_regs_monitor (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [9:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [9:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        ifPdClk,
	input wire logic [8:0]  ifRefDividerApplied,
	input wire logic        ifPllRun,
	input wire logic        ifBiasHigh,
	input wire logic [8:0]  ifPumpCurrentUa,
	input wire logic [2:0]  calProgress
);
	// The host offers both write halves together, so one edge marks a whole write.
	wire       wrGo  = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
	wire [7:0] wrIdx = s_axi_awaddr[9:2];
	wire       rdGo  = s_axi_arvalid & s_axi_arready;
	wire [7:0] rdIdx = s_axi_araddr[9:2];
	wire       ctlGo = wrGo && wrIdx == 8'h50;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	rb_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed before it was taken");
	ro_write_a: assert property (wrGo && wrIdx >= 8'hC8 && wrIdx <= 8'hCE |-> ##[1:2] s_axi_bresp == 2'b10 && s_axi_bvalid)
		else $error("write to a readback register was not refused");
	rb_read_a: assert property (rdGo && rdIdx >= 8'hC8 && rdIdx <= 8'hCE |=> s_axi_rvalid && s_axi_rresp == 2'b00)
		else $error("readback read was not answered with okay");
	run_bit_a: assert property (wrGo && wrIdx == 8'h31 |-> ##2 ifPllRun == $past(s_axi_wdata[5], 2))
		else $error("loop run output does not follow control bit five");
	bias_bit_a: assert property (wrGo && wrIdx == 8'h3E |-> ##2 ifBiasHigh == $past(s_axi_wdata[7], 2))
		else $error("bias output does not follow current bit seven");
	pump_step_a: assert property (ifPumpCurrentUa >= 9'h019 && ifPumpCurrentUa <= 9'h190 && ifPumpCurrentUa % 9'h019 == 9'h000)
		else $error("pump current is off its step grid");
	bias_start_a: assert property (ctlGo && s_axi_wdata[0] |-> ##[1:4] calProgress[0])
		else $error("bias calibration did not start");
	hf_start_a: assert property (ctlGo && s_axi_wdata[1] |-> ##[1:4] calProgress[1])
		else $error("high band calibration flag did not rise");
	zero_start_a: assert property (ctlGo && s_axi_wdata[2:0] == 3'b000 && calProgress == 3'b000 |=> (calProgress == 3'b000) [*3])
		else $error("zero start bits began a calibration");
	ref_sync_a: assert property (!$stable(ifRefDividerApplied) |-> $past(ifPdClk, 2) || $past(ifPdClk, 3) || $past(ifPdClk, 4))
		else $error("reference divider applied without a detector clock edge");

	cover property (ctlGo && s_axi_wdata[0]);
	cover property (rdGo && rdIdx == 8'hCA);
	cover property ($rose(calProgress[2]));
endmodule
bind sdvc_regs sdvc_regs_monitor mon (.*);
`default_nettype wire

//--- tb/sdvc_regs_bench.sv
// Self-checking bench for the divider and calibration register bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin totalChecks++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module sdvc_regs_bench;
	logic        mclk = 1'b0, reset_n = 1'b0, ce = 1'b1, ifPdClk = 1'b0;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ifPllRun, ifBiasHigh, usTick;
	logic [35:0] rfDivRatio;
	logic [6:0]  rfRefDivider;
	logic [13:0] ifFeedbackDivider;
	logic [8:0]  ifRefDividerApplied, ifPumpCurrentUa, hfOscCalCode, lfOscCalCode;
	logic [4:0]  biasCalCode;
	logic [9:0]  hfOscCalCycles;
	logic [2:0]  calProgress;
	int          fails = 0, totalChecks = 0;

	// A short laboratory calibration keeps the run brief; expectations use the same figure.
	sdvc_regs #(.LF_CAL_US(8)) uut (.*);
	sdvc_host_model host (.*);

	// Free-running 25 MHz clock.
	always #20 mclk = ~mclk;

	task automatic testDone();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One access with its response code judged; a hung bus ends the run at once.
	task automatic acc(input logic wr, input logic [7:0] i, input logic [31:0] d, input logic [1:0] er,
		output logic [31:0] q);
		logic [1:0] r;
		logic       ok;
		host.xfer(wr, {i, 2'b00}, d, q, r, ok);
		`CHK("bus answer", 1'b1, ok)
		if (ok !== 1'b1) begin
			testDone();
		end
		`CHK("response", er, r)
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, i, d, 2'b00, q);
	endtask

	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, i, 32'h0000_0000, 2'b00, q);
		`CHK("read data", e, q)
	endtask

	// Measures the spacing of two timebase ticks under a bounded wait.
	task automatic tickGap(input int n);
		int k;
		for (k = 0; k < 300 && usTick !== 1'b1; k++) @(posedge mclk);
		@(posedge mclk);
		for (k = 1; k < 300 && usTick !== 1'b1; k++) @(posedge mclk);
		`CHK("tick gap", n, k)
		if (k >= 300) begin
			testDone();
		end
	endtask

	// Starts one calibration and times its busy flag; the window allows two ticks and three cycles of slack below and one tick above.
	task automatic calRun(input int div, input int b, input int us);
		logic [31:0] q;
		int          n;
		acc(1'b1, 8'h50, 32'(div * 256 + (1 << b)), 2'b00, q);
		`CHK("busy flags", 3'(1 << b), calProgress)
		for (n = 0; n < 12000 && calProgress[b] === 1'b1; n++) @(posedge mclk);
		`CHK("busy time", 1'b1, (n + 2 * div + 3 >= us * div) && (n <= us * div + div))
		if (n >= 12000) begin
			testDone();
		end
	endtask

	task automatic tReset();
		rd(8'hC8, 32'h0000_0000);
		rd(8'hC9, 32'h0000_0080);
		rd(8'hCC, 32'h0000_0080);
		rd(8'hCD, 32'h0000_0002);
		rd(8'hCE, 32'h0000_0000);
		`CHK("pump current", 9'h019, ifPumpCurrentUa)
		`CHK("cycle count", 10'h15E, hfOscCalCycles)
		`CHK("progress", 3'b000, calProgress)
		tickGap(20);
		$display("test reset done");
	endtask

	task automatic tReadback();
		logic [31:0] v [7] = '{32'h0000_007F, 32'h0000_07FF, 32'h0000_8000, 32'h0000_0080,
			32'h0000_0019, 32'h0000_01FF, 32'h0000_008F};
		for (int i = 0; i < 7; i++) wr(8'h38 + 8'(i), v[i]);
		for (int i = 0; i < 7; i++) rd(8'hC8 + 8'(i), v[i]);
		`CHK("feedback div", 14'h0019, ifFeedbackDivider)
		`CHK("ref div", 7'h7F, rfRefDivider)
		`CHK("bias high", 1'b1, ifBiasHigh)
		for (int c = 0; c < 16; c++) begin
			wr(8'h3E, 32'(c));
			`CHK("pump current", 9'(25 * (c + 1)), ifPumpCurrentUa)
		end
		`CHK("bias low", 1'b0, ifBiasHigh)
		$display("test readback done");
	endtask

	task automatic tFraction();
		wr(8'h39, 32'h0000_0100);
		wr(8'h3B, 32'h0000_007F);
		wr(8'h3A, 32'h0000_8000);
		wr(8'h30, 32'h0000_0002);
		`CHK("ratio 24 bit", 36'h1_007F_8000, rfDivRatio)
		wr(8'h30, 32'h0000_0000);
		`CHK("ratio 16 bit", 36'h0_FF80_0000, rfDivRatio)
		wr(8'h30, 32'h0000_0001);
		`CHK("ratio integer", 36'h1_0000_0000, rfDivRatio)
		wr(8'h30, 32'h0000_0003);
		`CHK("ratio integer", 36'h1_0000_0000, rfDivRatio)
		wr(8'h31, 32'h0000_0020);
		`CHK("loop run", 1'b1, ifPllRun)
		wr(8'h30, 32'h0000_0002);
		wr(8'h3A, 32'h0000_0001);
		`CHK("ratio live", 36'h1_007F_0001, rfDivRatio)
		wr(8'h31, 32'h0000_0000);
		`CHK("loop stop", 1'b0, ifPllRun)
		$display("test fraction done");
	endtask

	task automatic tErrors();
		logic [31:0] q;
		acc(1'b1, 8'hC8, 32'h0000_0011, 2'b10, q);
		acc(1'b1, 8'h70, 32'h0000_0011, 2'b10, q);
		acc(1'b0, 8'h3C, 32'h0000_0000, 2'b10, q);
		`CHK("refused data", 32'h0000_0000, q)
		acc(1'b0, 8'h00, 32'h0000_0000, 2'b10, q);
		rd(8'hC8, 32'h0000_007F);
		rd(8'h5E, 32'h0000_0000);
		$display("test errors done");
	endtask

	task automatic tRefSync();
		wr(8'h3D, 32'h0000_0005);
		`CHK("ref div held", 9'h002, ifRefDividerApplied)
		repeat (2) begin
			ifPdClk <= 1'b1;
			repeat (3) @(posedge mclk);
			ifPdClk <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		`CHK("ref div applied", 9'h005, ifRefDividerApplied)
		$display("test ref sync done");
	endtask

	// Bias calibration runs first, as the host is expected to order them.
	task automatic tCal();
		wr(8'h51, 32'h0000_001F);
		wr(8'h53, 32'h0000_01FF);
		wr(8'h57, 32'h0000_0155);
		wr(8'h54, 32'h0000_03FF);
		`CHK("bias code", 5'h1F, biasCalCode)
		`CHK("hf code", 9'h1FF, hfOscCalCode)
		`CHK("lf code", 9'h155, lfOscCalCode)
		`CHK("cycle count", 10'h3FF, hfOscCalCycles)
		wr(8'h50, 32'h0000_1400);
		`CHK("no start", 3'b000, calProgress)
		calRun(20, 0, 6);
		calRun(20, 1, 452);
		wr(8'h50, 32'h0000_0300);
		tickGap(3);
		wr(8'h52, 32'h0000_003F);
		calRun(3, 0, 63);
		calRun(3, 2, 8);
		$display("test calibration done");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		tReset();
		tReadback();
		tFraction();
		tErrors();
		tRefSync();
		tCal();
		testDone();
	end
endmodule
`default_nettype wire
